// ---- rtl/rmc_map.vh ----
// constants for the radio mode controller: commands, state codes, timing counts
`ifndef RMC_MAP_VH
`define RMC_MAP_VH
`define RMC_CMD_PREFIX 8'h80
`define RMC_CMD_TX 8'h60
`define RMC_CMD_RX 8'h61
`define RMC_CMD_READY 8'h62
`define RMC_CMD_STANDBY 8'h63
`define RMC_CMD_SLEEP 8'h64
`define RMC_CMD_LOCK_RECEIVE_CMD 8'h65
`define RMC_CMD_LOCK_TRANSMIT_CMD 8'h66
`define RMC_CMD_ABORT 8'h67
`define RMC_CMD_DUTY_RELOAD 8'h68
`define RMC_CMD_SOFT_RESET 8'h70
`define RMC_CMD_CLR_RXQ 8'h71
`define RMC_CMD_CLR_TXQ 8'h72
`define RMC_CMD_SEQ_RELOAD 8'h73
`define RMC_CODE_READY 7'h00
`define RMC_CODE_SLEEP_NR 7'h01
`define RMC_CODE_STANDBY 7'h02
`define RMC_CODE_SLEEP_R 7'h03
`define RMC_CODE_LOCK 7'h0C
`define RMC_CODE_RX 7'h30
`define RMC_CODE_SETUP 7'h50
`define RMC_CODE_TX 7'h5C
`define RMC_SLEEP_SEL_REG 8'h79
`define RMC_CLK_MHZ 200
`define RMC_T_LOCK_NOCAL_US 45
`define RMC_T_LOCK_CAL_US 80
`define RMC_T_SLEEP_NS 300
`define RMC_T_TO_READY_US 1
`define RMC_T_WAKE_US 100
`define RMC_T_POWERUP_US 500
`define RMC_CYC_LOCK_NOCAL (`RMC_T_LOCK_NOCAL_US * `RMC_CLK_MHZ)
`define RMC_CYC_LOCK_CAL (`RMC_T_LOCK_CAL_US * `RMC_CLK_MHZ)
`define RMC_CYC_SLEEP ((`RMC_T_SLEEP_NS * `RMC_CLK_MHZ + 999) / 1000)
`define RMC_CYC_TO_READY (`RMC_T_TO_READY_US * `RMC_CLK_MHZ)
`define RMC_CYC_WAKE (`RMC_T_WAKE_US * `RMC_CLK_MHZ)
`define RMC_CYC_POWERUP (`RMC_T_POWERUP_US * `RMC_CLK_MHZ)
`endif

// ---- rtl/rmc_spi_rx.v ----
// spi slave byte receiver: shifts mosi in on sck rising edges, mode 0, msb first
`timescale 1ns/1ps
module rmc_spi_rx (
  input wire clk,
  input wire srst,
  input wire csn,
  input wire sck,
  input wire mosi,
  output reg [7:0] byte_data_reg,
  output reg byte_valid_reg,
  output reg first_byte_reg
);
  reg sck_d_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg first_pending_reg;
  wire sck_rise;
  wire [7:0] shift_next;

  // sck is sampled like any other synchronous input; edges found by comparing two samples
  assign sck_rise = sck & ~sck_d_reg;
  assign shift_next = {shift_reg[6:0], mosi};

  //////////////////////////////////////////////////////////////////////////////
  // shifter: chip select high parks the bit counter, so a broken byte never completes
  always @(posedge clk) begin
    if (srst) begin
      sck_d_reg <= 1'b0;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_data_reg <= 8'h00;
      byte_valid_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      first_pending_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck;
      byte_valid_reg <= 1'b0;
      if (csn) begin
        bit_cnt_reg <= 3'h0;
        first_pending_reg <= 1'b1;
      end else if (sck_rise) begin
        shift_reg <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          byte_data_reg <= shift_next;
          byte_valid_reg <= 1'b1;
          first_byte_reg <= first_pending_reg;
          first_pending_reg <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- rtl/rmc_mode_ctrl.v ----
// radio mode controller: spi command decode and main operating-state sequencer
`timescale 1ns/1ps
`include "rmc_map.vh"
module rmc_mode_ctrl #(
  parameter [15:0] LOCK_NOCAL_CYC = `RMC_CYC_LOCK_NOCAL,
  parameter [15:0] LOCK_CAL_CYC = `RMC_CYC_LOCK_CAL,
  parameter [15:0] WAKE_CYC = `RMC_CYC_WAKE,
  parameter [16:0] POWERUP_CYC = `RMC_CYC_POWERUP
) (
  input wire clk,
  input wire srst,
  input wire power_down_pin,
  input wire spi_csn,
  input wire spi_sck,
  input wire spi_mosi,
  input wire vco_cal_en,
  input wire sleep_retain_sel,
  input wire rx_done,
  input wire tx_done,
  input wire hw_sleep_req,
  output reg [6:0] state_code_reg,
  output reg xtal_on_reg,
  output reg synth_on_reg,
  output reg synth_tx_cfg_reg,
  output reg wake_timer_on_reg,
  output reg rx_active_reg,
  output reg tx_active_reg,
  output reg powered_reg,
  output reg duty_timer_reload_cmd,
  output reg soft_reset_cmd,
  output reg clear_receive_queue_cmd,
  output reg clear_transmit_queue_cmd,
  output reg seq_reload_cmd,
  output reg sleep_retain_reg
);
  // one-hot states
  localparam [9:0] ST_OFF = 10'h001;
  localparam [9:0] ST_READY = 10'h002;
  localparam [9:0] ST_STANDBY = 10'h004;
  localparam [9:0] ST_SLEEP = 10'h008;
  localparam [9:0] ST_SETUP = 10'h010;
  localparam [9:0] ST_LOCK = 10'h020;
  localparam [9:0] ST_RX = 10'h040;
  localparam [9:0] ST_TX = 10'h080;
  localparam [9:0] ST_GO_LOW = 10'h100;
  localparam [9:0] ST_TO_READY = 10'h200;
  // where the lock phase goes when done
  localparam [1:0] GOAL_LOCK = 2'h0;
  localparam [1:0] GOAL_RX = 2'h1;
  localparam [1:0] GOAL_TX = 2'h2;
  localparam [15:0] SLEEP_CYC = `RMC_CYC_SLEEP;
  localparam [15:0] TO_READY_CYC = `RMC_CYC_TO_READY;

  wire [7:0] byte_data;
  wire byte_valid;
  wire first_byte;
  reg [9:0] state_reg;
  reg [9:0] state_next;
  reg [16:0] timer_reg;
  reg [16:0] timer_next;
  reg [1:0] goal_reg;
  reg [1:0] goal_next;
  reg low_is_sleep_reg;
  reg low_is_sleep_next;
  reg prefix_seen_reg;
  reg cmd_valid;
  reg [7:0] cmd;
  reg soft_reset_next;

  // state code for each one-hot state
  function [6:0] code_of;
    input [9:0] st;
    input retain;
    begin
      case (st)
        ST_READY: code_of = `RMC_CODE_READY;
        ST_STANDBY: code_of = `RMC_CODE_STANDBY;
        ST_SLEEP: code_of = retain ? `RMC_CODE_SLEEP_R : `RMC_CODE_SLEEP_NR;
        ST_SETUP: code_of = `RMC_CODE_SETUP;
        ST_LOCK: code_of = `RMC_CODE_LOCK;
        ST_RX: code_of = `RMC_CODE_RX;
        ST_TX: code_of = `RMC_CODE_TX;
        ST_GO_LOW: code_of = `RMC_CODE_READY;
        ST_TO_READY: code_of = `RMC_CODE_READY;
        default: code_of = 7'h7F;
      endcase
    end
  endfunction

  // one compare serves every strobe except soft reset, and the lock-direction choice below
  function cmd_is;
    input valid;
    input [7:0] code;
    input [7:0] want;
    begin
      cmd_is = valid && (code == want);
    end
  endfunction

  // true only in the cycle the sequencer steps into sleep, so entry actions fire once
  function enters_sleep;
    input [9:0] nxt;
    input [9:0] cur;
    begin
      enters_sleep = (nxt == ST_SLEEP) && (cur != ST_SLEEP);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  rmc_spi_rx u_spi (
    .clk(clk),
    .srst(srst | power_down_pin),
    .csn(spi_csn),
    .sck(spi_sck),
    .mosi(spi_mosi),
    .byte_data_reg(byte_data),
    .byte_valid_reg(byte_valid),
    .first_byte_reg(first_byte)
  );

  // the second byte after a 0x80 first byte is a command; later bytes are other accesses
  always @* begin
    cmd_valid = byte_valid & prefix_seen_reg & ~first_byte;
    cmd = byte_data;
  end

  always @(posedge clk) begin
    if (srst | power_down_pin) begin
      prefix_seen_reg <= 1'b0;
    end else if (byte_valid) begin
      prefix_seen_reg <= first_byte & (byte_data == `RMC_CMD_PREFIX);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic; invalid commands leave everything as it is
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    goal_next = goal_reg;
    low_is_sleep_next = low_is_sleep_reg;
    soft_reset_next = 1'b0;
    if (timer_reg != 17'h0) begin
      timer_next = timer_reg - 17'h1;
    end
    case (state_reg)
      ST_OFF: begin
        // commands other than soft reset and the duty, queue-clear and sequencer-reload strobes are dropped here; the host must wait out the power-up delay
        if (timer_reg == 17'h0) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        if (cmd_valid) begin
          case (cmd)
            `RMC_CMD_TX, `RMC_CMD_RX, `RMC_CMD_LOCK_RECEIVE_CMD, `RMC_CMD_LOCK_TRANSMIT_CMD: begin
              state_next = ST_SETUP;
              goal_next = (cmd == `RMC_CMD_TX) ? GOAL_TX :
                          (cmd == `RMC_CMD_RX) ? GOAL_RX : GOAL_LOCK;
              // calibration costs extra settling time
              timer_next = {1'b0, vco_cal_en ? LOCK_CAL_CYC : LOCK_NOCAL_CYC};
            end
            `RMC_CMD_STANDBY: begin
              state_next = ST_GO_LOW;
              low_is_sleep_next = 1'b0;
              timer_next = {1'b0, SLEEP_CYC};
            end
            `RMC_CMD_SLEEP: begin
              state_next = ST_GO_LOW;
              low_is_sleep_next = 1'b1;
              timer_next = {1'b0, SLEEP_CYC};
            end
            default: state_next = ST_READY;
          endcase
        end else if (hw_sleep_req) begin
          // duty-cycle or csma entry obeys the same variant bit as the command
          state_next = ST_GO_LOW;
          low_is_sleep_next = 1'b1;
          timer_next = {1'b0, SLEEP_CYC};
        end
      end
      ST_GO_LOW: begin
        if (timer_reg == 17'h0) begin
          state_next = low_is_sleep_reg ? ST_SLEEP : ST_STANDBY;
        end
      end
      ST_STANDBY, ST_SLEEP: begin
        if (cmd_valid && cmd == `RMC_CMD_READY) begin
          state_next = ST_TO_READY;
          timer_next = {1'b0, WAKE_CYC};
        end
      end
      ST_SETUP: begin
        if (timer_reg == 17'h0) begin
          state_next = ST_LOCK;
        end
      end
      ST_LOCK: begin
        // lock used only on the way to rx/tx is passed straight through
        if (goal_reg == GOAL_RX) begin
          state_next = ST_RX;
        end else if (goal_reg == GOAL_TX) begin
          state_next = ST_TX;
        end else if (cmd_valid && cmd == `RMC_CMD_READY) begin
          state_next = ST_TO_READY;
          timer_next = {1'b0, TO_READY_CYC};
        end
      end
      ST_RX, ST_TX: begin
        if (cmd_valid && cmd == `RMC_CMD_ABORT) begin
          state_next = ST_TO_READY;
          timer_next = {1'b0, TO_READY_CYC};
        end else if (state_reg == ST_RX && cmd_valid && cmd == `RMC_CMD_TX) begin
          // direction swap reuses the running synthesizer: one cycle of lock
          state_next = ST_LOCK;
          goal_next = GOAL_TX;
        end else if (state_reg == ST_TX && cmd_valid && cmd == `RMC_CMD_RX) begin
          state_next = ST_LOCK;
          goal_next = GOAL_RX;
        end else if ((state_reg == ST_RX && rx_done) || (state_reg == ST_TX && tx_done)) begin
          state_next = ST_TO_READY;
          timer_next = {1'b0, TO_READY_CYC};
        end
      end
      ST_TO_READY: begin
        // shows the ready code already but takes no command except soft reset and the other strobe commands until the timer ends;
        // a host must allow the whole transition time before its next command
        if (timer_reg == 17'h0) begin
          state_next = ST_READY;
        end
      end
      default: state_next = ST_READY;
    endcase
    // soft reset overrides any state
    if (cmd_valid && cmd == `RMC_CMD_SOFT_RESET) begin
      state_next = ST_READY;
      timer_next = 17'h0;
      goal_next = GOAL_LOCK;
      low_is_sleep_next = 1'b0;
      soft_reset_next = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state registers; the power-down pin wipes everything and starts the power-up delay
  always @(posedge clk) begin
    if (srst | power_down_pin) begin
      state_reg <= ST_OFF;
      timer_reg <= POWERUP_CYC;
      goal_reg <= GOAL_LOCK;
      low_is_sleep_reg <= 1'b0;
      sleep_retain_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      goal_reg <= goal_next;
      low_is_sleep_reg <= low_is_sleep_next;
      // retention choice latched at each sleep entry, held while asleep
      if (enters_sleep(state_next, state_reg)) begin
        sleep_retain_reg <= sleep_retain_sel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered status and one-cycle command strobes
  always @(posedge clk) begin
    if (srst | power_down_pin) begin
      state_code_reg <= 7'h7F;
      xtal_on_reg <= 1'b0;
      synth_on_reg <= 1'b0;
      wake_timer_on_reg <= 1'b0;
      rx_active_reg <= 1'b0;
      tx_active_reg <= 1'b0;
      powered_reg <= 1'b0;
      duty_timer_reload_cmd <= 1'b0;
      soft_reset_cmd <= 1'b0;
      clear_receive_queue_cmd <= 1'b0;
      clear_transmit_queue_cmd <= 1'b0;
      seq_reload_cmd <= 1'b0;
    end else begin
      state_code_reg <= code_of(state_next, (state_next == ST_SLEEP) ?
        ((state_reg == ST_SLEEP) ? sleep_retain_reg : sleep_retain_sel) : 1'b0);
      xtal_on_reg <= ~(state_next == ST_OFF || state_next == ST_STANDBY ||
        state_next == ST_SLEEP);
      synth_on_reg <= (state_next == ST_SETUP) || (state_next == ST_LOCK) ||
        (state_next == ST_RX) || (state_next == ST_TX);
      wake_timer_on_reg <= (state_next == ST_SLEEP);
      rx_active_reg <= (state_next == ST_RX);
      tx_active_reg <= (state_next == ST_TX);
      powered_reg <= 1'b1;
      duty_timer_reload_cmd <= cmd_is(cmd_valid, cmd, `RMC_CMD_DUTY_RELOAD);
      soft_reset_cmd <= soft_reset_next;
      // entering sleep without retention drops both queues
      clear_receive_queue_cmd <= cmd_is(cmd_valid, cmd, `RMC_CMD_CLR_RXQ) ||
        (enters_sleep(state_next, state_reg) && !sleep_retain_sel);
      clear_transmit_queue_cmd <= cmd_is(cmd_valid, cmd, `RMC_CMD_CLR_TXQ) ||
        (enters_sleep(state_next, state_reg) && !sleep_retain_sel);
      seq_reload_cmd <= cmd_is(cmd_valid, cmd, `RMC_CMD_SEQ_RELOAD);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // synthesizer setting: picked by the command that starts a lock phase and held after it,
  // so a lock entered for transmit keeps the transmit setting while it stands
  always @(posedge clk) begin
    if (srst | power_down_pin) begin
      synth_tx_cfg_reg <= 1'b0;
    end else if (soft_reset_next) begin
      synth_tx_cfg_reg <= 1'b0;
    end else if (state_reg == ST_READY && cmd_valid) begin
      if (cmd_is(1'b1, cmd, `RMC_CMD_TX) || cmd_is(1'b1, cmd, `RMC_CMD_LOCK_TRANSMIT_CMD)) begin
        synth_tx_cfg_reg <= 1'b1;
      end else if (cmd_is(1'b1, cmd, `RMC_CMD_RX) || cmd_is(1'b1, cmd, `RMC_CMD_LOCK_RECEIVE_CMD)) begin
        synth_tx_cfg_reg <= 1'b0;
      end
    end else if ((state_reg == ST_RX || state_reg == ST_TX) && state_next == ST_LOCK) begin
      // a direction swap retunes during its lock cycle
      synth_tx_cfg_reg <= (goal_next == GOAL_TX);
    end
  end
endmodule

// ---- bench/rmc_mode_ctrl_assertions.sv ----
// checker: state code and output relations of the mode controller
`timescale 1ns/1ps
`include "rmc_map.vh"
module rmc_mode_ctrl_assertions (
  input wire clk,
  input wire srst,
  input wire power_down_pin,
  input wire [6:0] state_code_reg,
  input wire xtal_on_reg,
  input wire synth_on_reg,
  input wire wake_timer_on_reg,
  input wire rx_active_reg,
  input wire tx_active_reg,
  input wire powered_reg,
  input wire soft_reset_cmd,
  input wire sleep_retain_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // short aliases keep the properties on few lines
  wire [6:0] sc = state_code_reg;
  wire is_slp = (sc == `RMC_CODE_SLEEP_NR) || (sc == `RMC_CODE_SLEEP_R);
  //////////////////////////////
  // active states are only entered out of lock
  property p_rx_via_lock;
    $changed(sc) && sc == `RMC_CODE_RX |-> $past(sc) == `RMC_CODE_LOCK;
  endproperty
  a_rx_via_lock: assert property (p_rx_via_lock) else $error("rx not entered from lock");
  property p_tx_via_lock;
    $changed(sc) && sc == `RMC_CODE_TX |-> $past(sc) == `RMC_CODE_LOCK;
  endproperty
  a_tx_via_lock: assert property (p_tx_via_lock) else $error("tx not entered from lock");
  // activity flags must agree with the reported code
  property p_active_flag;
    rx_active_reg || tx_active_reg |-> sc inside {`RMC_CODE_RX, `RMC_CODE_TX};
  endproperty
  a_active_flag: assert property (p_active_flag) else $error("active flag off its state");
  property p_code_legal;
    sc inside {7'h00, 7'h01, 7'h02, 7'h03, 7'h0C, 7'h30, 7'h50, 7'h5C, 7'h7F};
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("state code not in table");
  // supply pattern of the lock, standby and sleep states
  property p_lock_synth;
    sc == `RMC_CODE_LOCK |-> synth_on_reg && xtal_on_reg;
  endproperty
  a_lock_synth: assert property (p_lock_synth) else $error("lock without synth or xtal");
  property p_standby_off;
    sc == `RMC_CODE_STANDBY |-> !xtal_on_reg && !wake_timer_on_reg;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("standby with xtal or timer");
  property p_sleep_off;
    is_slp |-> wake_timer_on_reg && !xtal_on_reg && !synth_on_reg;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep supply pattern wrong");
  property p_sleep_variant;
    is_slp |-> sc == (sleep_retain_reg ? `RMC_CODE_SLEEP_R : `RMC_CODE_SLEEP_NR);
  endproperty
  a_sleep_variant: assert property (p_sleep_variant) else $error("sleep code vs variant");
  // shutdown must wipe state at the very next edge
  property p_pd_off;
    power_down_pin |=> sc == 7'h7F && !powered_reg;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("power down did not clear state");
  property p_soft_reset;
    soft_reset_cmd |=> !soft_reset_cmd && sc == `RMC_CODE_READY;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not to ready");
  c_rx: cover property (sc == `RMC_CODE_RX);
  c_sleep_r: cover property (sc == `RMC_CODE_SLEEP_R);
  c_soft_reset: cover property (soft_reset_cmd);
endmodule
bind rmc_mode_ctrl rmc_mode_ctrl_assertions u_rmc_mode_ctrl_assertions (
  .clk(clk), .srst(srst), .power_down_pin(power_down_pin), .state_code_reg(state_code_reg),
  .xtal_on_reg(xtal_on_reg), .synth_on_reg(synth_on_reg),
  .wake_timer_on_reg(wake_timer_on_reg), .rx_active_reg(rx_active_reg),
  .tx_active_reg(tx_active_reg), .powered_reg(powered_reg),
  .soft_reset_cmd(soft_reset_cmd), .sleep_retain_reg(sleep_retain_reg));

// ---- bench/rmc_host_model.sv ----
// host model: spi master sending two-byte command frames, mode 0
`timescale 1ns/1ps
module rmc_host_model (
  input wire clk,
  output logic spi_csn,
  output logic spi_sck,
  output logic spi_mosi
);
  // idle: deselected, clock parked low
  initial begin
    spi_csn = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b1;
  end
  //////////////////////////////
  // three clk per sck high phase and four per low phase, above the two the slave needs
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) spi_mosi <= b[i];
      repeat (3) @(posedge clk);
      spi_sck <= 1'b1;
      repeat (3) @(posedge clk);
      spi_sck <= 1'b0;
    end
  endtask
  // one command per frame; data line flips on release so stale bits never look valid
  task automatic send_cmd(input logic [7:0] pre, input logic [7:0] c);
    @(posedge clk) spi_csn <= 1'b0;
    repeat (2) @(posedge clk);
    send_byte(pre);
    send_byte(c);
    repeat (3) @(posedge clk);
    spi_csn <= 1'b1;
    spi_mosi <= ~spi_mosi;
  endtask
endmodule

// ---- bench/radio_mode_controller_tb.sv ----
// testbench for the radio mode controller: frames, timing, strobes
`timescale 1ns/1ps
`include "rmc_map.vh"
module radio_mode_controller_tb;
  localparam int NC = 20;
  localparam int CAL = 40;
  localparam int WK = 10;
  localparam int PU = 10;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pd = 1'b0;
  logic vco = 1'b0;
  logic sel = 1'b0;
  logic rxd = 1'b0;
  logic txd = 1'b0;
  logic hsr = 1'b0;
  wire csn, sck, mosi, xtal, synth, stx, wkt, rxa, txa, pwr, ret;
  wire [6:0] code;
  wire [4:0] stb;
  int n_fail = 0;
  int samples_checked = 0;
  int wcyc;
  int cnt[5] = '{default: 0};
  int c0[5];
  rmc_host_model u_rmc_host_model (.clk(clk), .spi_csn(csn), .spi_sck(sck), .spi_mosi(mosi));
  rmc_mode_ctrl #(.LOCK_NOCAL_CYC(16'(NC)), .LOCK_CAL_CYC(16'(CAL)), .WAKE_CYC(16'(WK)),
    .POWERUP_CYC(17'(PU))) u_rmc_mode_ctrl (
    .clk(clk), .srst(srst), .power_down_pin(pd), .spi_csn(csn), .spi_sck(sck),
    .spi_mosi(mosi), .vco_cal_en(vco), .sleep_retain_sel(sel), .rx_done(rxd),
    .tx_done(txd), .hw_sleep_req(hsr), .state_code_reg(code), .xtal_on_reg(xtal),
    .synth_on_reg(synth), .synth_tx_cfg_reg(stx), .wake_timer_on_reg(wkt),
    .rx_active_reg(rxa), .tx_active_reg(txa), .powered_reg(pwr),
    .duty_timer_reload_cmd(stb[0]), .soft_reset_cmd(stb[1]),
    .clear_receive_queue_cmd(stb[2]), .clear_transmit_queue_cmd(stb[3]),
    .seq_reload_cmd(stb[4]), .sleep_retain_reg(ret));
  always #2.5 clk = ~clk;
  // strobes are counted so a test can tell one pulse from none or two
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (stb[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
  end
  //////////////////////////////
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bounded wait; a miss counts and ends the run
  task automatic wait_code(input logic [6:0] c, input int lim);
    wcyc = 0;
    while (code !== c && wcyc < lim) begin
      @(posedge clk) #1;
      wcyc++;
    end
    if (code !== c) begin
      chk(code, c);
      final_report();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    u_rmc_host_model.send_cmd(`RMC_CMD_PREFIX, c);
    repeat (2) @(posedge clk);
    #1;
  endtask
  // measures setup-to-target time while the frame is still on the wire
  task automatic timed(input logic [7:0] c, input logic [6:0] tgt, input int n);
    #1;
    fork
      u_rmc_host_model.send_cmd(`RMC_CMD_PREFIX, c);
    join_none
    wait_code(`RMC_CODE_SETUP, 400);
    wait_code(tgt, n + 10);
    chk(7'(wcyc), 7'(n));
  endtask
  //////////////////////////////
  task automatic t_power();
    repeat (2) @(posedge clk);
    #1;
    chk(code, 7'h7F);
    @(posedge clk) srst <= 1'b0;
    #1;
    wait_code(`RMC_CODE_READY, PU + 20);
    chk(7'(pwr), 7'h01);
    @(posedge clk) pd <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(code, 7'h7F);
    chk(7'(pwr), 7'h00);
    @(posedge clk) pd <= 1'b0;
    #1;
    wait_code(`RMC_CODE_READY, PU + 20);
    chk(7'(wcyc >= PU - 1), 7'h01);
    $display("test power done");
  endtask
  task automatic t_rx();
    timed(`RMC_CMD_RX, `RMC_CODE_RX, NC + 2);
    chk(7'(rxa), 7'h01);
    cmd(`RMC_CMD_ABORT);
    chk(code, `RMC_CODE_READY);
    chk(7'(rxa), 7'h00);
    repeat (`RMC_CYC_TO_READY + 10) @(posedge clk);
    cmd(`RMC_CMD_RX);
    wait_code(`RMC_CODE_RX, NC + 20);
    @(posedge clk) rxd <= 1'b1;
    @(posedge clk) rxd <= 1'b0;
    #1;
    chk(code, `RMC_CODE_READY);
    repeat (`RMC_CYC_TO_READY + 10) @(posedge clk);
    $display("test rx done");
  endtask
  task automatic t_tx();
    @(posedge clk) vco <= 1'b1;
    timed(`RMC_CMD_TX, `RMC_CODE_TX, CAL + 2);
    chk(7'(txa), 7'h01);
    chk(7'(stx), 7'h01);
    cmd(`RMC_CMD_RX);
    wait_code(`RMC_CODE_RX, 20);
    chk(7'(rxa & ~txa), 7'h01);
    chk(7'(stx), 7'h00);
    cmd(`RMC_CMD_TX);
    wait_code(`RMC_CODE_TX, 20);
    chk(7'(txa & ~rxa & stx), 7'h01);
    @(posedge clk) txd <= 1'b1;
    @(posedge clk) txd <= 1'b0;
    vco <= 1'b0;
    #1;
    chk(code, `RMC_CODE_READY);
    repeat (`RMC_CYC_TO_READY + 10) @(posedge clk);
    $display("test tx done");
  endtask
  task automatic t_lock();
    cmd(`RMC_CMD_LOCK_RECEIVE_CMD);
    wait_code(`RMC_CODE_LOCK, NC + 20);
    chk(7'(stx), 7'h00);
    chk(7'(synth & xtal), 7'h01);
    repeat (3 * NC) @(posedge clk);
    cmd(`RMC_CMD_STANDBY);
    chk(code, `RMC_CODE_LOCK);
    cmd(`RMC_CMD_READY);
    wait_code(`RMC_CODE_READY, 20);
    repeat (`RMC_CYC_TO_READY) @(posedge clk);
    cmd(`RMC_CMD_LOCK_TRANSMIT_CMD);
    wait_code(`RMC_CODE_LOCK, NC + 20);
    chk(7'(stx), 7'h01);
    cmd(`RMC_CMD_READY);
    wait_code(`RMC_CODE_READY, 20);
    repeat (`RMC_CYC_TO_READY) @(posedge clk);
    $display("test lock done");
  endtask
  task automatic t_standby();
    cmd(`RMC_CMD_STANDBY);
    wait_code(`RMC_CODE_STANDBY, 80);
    chk(7'(xtal), 7'h00);
    cmd(`RMC_CMD_RX);
    chk(code, `RMC_CODE_STANDBY);
    cmd(`RMC_CMD_READY);
    wait_code(`RMC_CODE_READY, WK + 40);
    $display("test standby done");
  endtask
  task automatic t_sleep();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk) sel <= v[0];
      c0 = cnt;
      cmd(`RMC_CMD_SLEEP);
      wait_code(v ? `RMC_CODE_SLEEP_R : `RMC_CODE_SLEEP_NR, 80);
      repeat (2) @(posedge clk);
      #1;
      chk(7'(ret), 7'(v));
      chk(7'(wkt & ~xtal), 7'h01);
      chk(7'(cnt[2] - c0[2]), 7'(1 - v));
      chk(7'(cnt[3] - c0[3]), 7'(1 - v));
      cmd(`RMC_CMD_READY);
      wait_code(`RMC_CODE_READY, WK + 40);
    end
    repeat (WK + 5) @(posedge clk); // wake transition must end before the request counts
    @(posedge clk) hsr <= 1'b1;
    @(posedge clk) hsr <= 1'b0;
    #1;
    wait_code(`RMC_CODE_SLEEP_R, 80);
    cmd(`RMC_CMD_READY);
    wait_code(`RMC_CODE_READY, WK + 40);
    @(posedge clk) sel <= 1'b0;
    $display("test sleep done");
  endtask
  task automatic t_any();
    logic [7:0] ops[4] = '{`RMC_CMD_DUTY_RELOAD, `RMC_CMD_CLR_RXQ, `RMC_CMD_CLR_TXQ,
      `RMC_CMD_SEQ_RELOAD};
    int idx[4] = '{0, 2, 3, 4};
    cmd(`RMC_CMD_LOCK_RECEIVE_CMD);
    wait_code(`RMC_CODE_LOCK, NC + 20);
    for (int i = 0; i < 4; i++) begin
      c0 = cnt;
      cmd(ops[i]);
      chk(7'(cnt[idx[i]] - c0[idx[i]]), 7'h01);
      chk(code, `RMC_CODE_LOCK);
    end
    u_rmc_host_model.send_cmd(8'h00, `RMC_CMD_READY);
    repeat (2) @(posedge clk);
    #1;
    chk(code, `RMC_CODE_LOCK);
    c0 = cnt;
    cmd(`RMC_CMD_SOFT_RESET);
    chk(code, `RMC_CODE_READY);
    chk(7'(cnt[1] - c0[1]), 7'h01);
    $display("test any-state done");
  endtask
  initial begin
    t_power();
    t_rx();
    t_tx();
    t_lock();
    t_standby();
    t_sleep();
    t_any();
    final_report();
  end
endmodule
